// ---- rsq_ramp_segment_sequencer.sv ----
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Eight independent sets of segment controls, indexed zero to seven.
// - Fast-lock bit set enables fast-lock and slip reduction during segment.
// - Half-rate bit: one tick per clock when 0, per two clocks when 1.
// - Segment runs length-field ticks; up to 65536.
// - Marker outputs load from the segment flag field at segment start.
// - Flag 0 none, 1 low, 2 high, 3 both markers.
// - Accumulator-clear bit zeroes accumulator at segment start.
// - Advance source: 0 length expiry, 1/2/3 triggers A/B/C.
// - Next segment is the ending segment's successor index.
module rsq_ramp_segment_sequencer (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [11:0]                    paddr,
  input  wire logic [31:0]                    pwdata,
  output var  logic [31:0]                    prdata,
  output var  logic                           pready,
  output var  logic                           pslverr,
  input  wire logic                           trigger_a,
  input  wire logic                           trigger_b,
  input  wire logic                           trigger_c,
  output var  rsq_pkg::rsq_out_t              ramp_out
);
  import rsq_pkg::*;

  // ==========================================================================
  // Control state
  rsq_state_t             state_ff;
  logic                   run_en_ff;
  logic [RSQ_SEG_W-1:0]   start_seg_ff;
  logic [RSQ_SEG_W-1:0]   seg_ff;
  logic [RSQ_LEN_W-1:0]   tick_cnt_ff;
  logic                   half_ff;
  logic                   load_ff;
  logic [RSQ_ACC_W-1:0]   acc_ff;
  logic [RSQ_CFG_W-1:0]   shadow_a_ff [RSQ_NSEG];
  rsq_seg_t               cur;
  logic [RSQ_CFG_W-1:0]   cur_raw;
  logic [RSQ_SEG_W-1:0]   rd_idx;
  logic                   tick;
  logic                   seg_done;
  logic [RSQ_SEG_W-1:0]   nxt_seg;

  // Address decode helpers used by both the read and the write paths
  function automatic logic seg_hit(input logic [11:0] a);
    seg_hit = (a >= RSQ_SEG_BASE) && (a < RSQ_SEG_END);
  endfunction
  function automatic logic [RSQ_SEG_W-1:0] seg_of(input logic [11:0] a);
    seg_of = a[5:3];
  endfunction
  // Word B fields joined to a stored increment; unused word B bits are dropped
  // here so the table entry stays exactly one segment struct wide
  function automatic logic [RSQ_CFG_W-1:0] pack_b(input logic [31:0]          d,
                                                  input logic [RSQ_INC_W-1:0] inc);
    pack_b = {d[RSQ_B_FL:RSQ_B_HR], d[RSQ_B_FLG+1:RSQ_B_FLG], d[RSQ_B_SRC+1:RSQ_B_SRC],
              d[RSQ_B_NXT+RSQ_SEG_W-1:RSQ_B_LEN], inc};
  endfunction
  // Table entry back into the word B layout for readback
  function automatic logic [31:0] unpack_b(input logic [RSQ_CFG_W-1:0] e);
    rsq_seg_t s;
    s                               = rsq_seg_t'(e);
    unpack_b                        = RSQ_ZERO32;
    unpack_b[RSQ_B_LEN+:RSQ_LEN_W] = s.length;
    unpack_b[RSQ_B_NXT+:RSQ_SEG_W] = s.successor;
    unpack_b[RSQ_B_SRC+:2]         = s.advance_source;
    unpack_b[RSQ_B_FLG+:2]         = s.flag_field;
    unpack_b[RSQ_B_HR]             = s.half_rate;
    unpack_b[RSQ_B_CLR]            = s.accum_clear;
    unpack_b[RSQ_B_FL]             = s.fast_lock;
  endfunction

  wire logic bus_wr = psel && penable && pwrite;
  wire logic bus_rd = psel && penable && !pwrite;
  wire logic seg_wr = bus_wr && seg_hit(paddr);

  // ==========================================================================
  // Per-segment storage. Word A lives in a shadow register bank so a write
  // of word B commits the whole segment in one memory write. Both words are
  // kept per segment and never shared.
  genvar g;
  generate
    for (g = 0; g < RSQ_NSEG; g++) begin : g_shadow
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          shadow_a_ff[g] <= RSQ_CFG_RST;
        end else if (seg_wr && !paddr[2] && seg_of(paddr) == g) begin
          shadow_a_ff[g] <= {shadow_a_ff[g][RSQ_CFG_W-1:RSQ_INC_W], pwdata[RSQ_INC_W-1:0]};
        end else if (seg_wr && paddr[2] && seg_of(paddr) == g) begin
          shadow_a_ff[g] <= pack_b(pwdata, shadow_a_ff[g][RSQ_INC_W-1:0]);
        end
      end
    end
  endgenerate

  // Live copy for the sequencer; reading the segment after it ends costs a
  // cycle, which the load cycle absorbs
  rsq_seg_mem #(
    .DEPTH (RSQ_NSEG),
    .AW    (RSQ_SEG_W),
    .W     (RSQ_CFG_W)
  ) u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (seg_wr && paddr[2]),
    .wr_idx  (seg_of(paddr)),
    .wr_data (pack_b(pwdata, shadow_a_ff[seg_of(paddr)][RSQ_INC_W-1:0])),
    .rd_idx  (rd_idx),
    .rd_data (cur_raw)
  );
  assign cur = rsq_seg_t'(cur_raw);

  // ==========================================================================
  // Sequencing
  always_comb begin
    unique case (cur.advance_source)
      RSQ_ADV_LEN:  seg_done = tick && (tick_cnt_ff == '0);
      RSQ_ADV_TRGA: seg_done = trigger_a;
      RSQ_ADV_TRGB: seg_done = trigger_b;
      default:      seg_done = trigger_c;
    endcase
  end
  assign tick    = !cur.half_rate || half_ff;
  assign nxt_seg = cur.successor;
  assign rd_idx  = (state_ff == RSQ_ST_RUN && !load_ff && seg_done) ? nxt_seg :
                   (state_ff == RSQ_ST_IDLE) ? start_seg_ff : seg_ff;

  // Segment state machine: load cycle fetches the table entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= RSQ_ST_IDLE;
      seg_ff   <= '0;
      load_ff  <= 1'b0;
    end else begin
      case (state_ff)
        RSQ_ST_IDLE: begin
          if (run_en_ff) begin
            state_ff <= RSQ_ST_RUN;
            seg_ff   <= start_seg_ff;
            load_ff  <= 1'b1;
          end
        end
        default: begin
          if (!run_en_ff) begin
            state_ff <= RSQ_ST_IDLE;
            load_ff  <= 1'b0;
          end else if (load_ff) begin
            load_ff <= 1'b0;
          end else if (seg_done) begin
            seg_ff  <= nxt_seg;
            load_ff <= 1'b1;
          end
        end
      endcase
    end
  end

  // Tick divider and length counter; stored value is length-1 so 65536 fits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_ff     <= 1'b0;
      tick_cnt_ff <= '0;
    end else if (load_ff) begin
      half_ff     <= 1'b0;
      tick_cnt_ff <= cur.length;
    end else if (state_ff == RSQ_ST_RUN) begin
      half_ff <= cur.half_rate ? !half_ff : 1'b0;
      if (tick && tick_cnt_ff != '0) begin
        tick_cnt_ff <= tick_cnt_ff - 1'b1;
      end
    end
  end

  // Accumulator: clear at segment start when asked, else add per tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff <= '0;
    end else if (load_ff) begin
      if (cur.accum_clear) begin
        acc_ff <= '0;
      end
    end else if (state_ff == RSQ_ST_RUN && tick) begin
      acc_ff <= acc_ff + {{(RSQ_ACC_W-RSQ_INC_W){cur.increment[RSQ_INC_W-1]}}, cur.increment};
    end
  end

  // Outputs toward divider logic, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_out <= '0;
    end else begin
      ramp_out.accum   <= acc_ff;
      ramp_out.segment <= seg_ff;
      ramp_out.fast_lock_en <= (state_ff == RSQ_ST_RUN) && !load_ff && cur.fast_lock;
      if (load_ff) begin
        ramp_out.ramp_marker_low  <= cur.flag_field[0];
        ramp_out.ramp_marker_high <= cur.flag_field[1];
      end
    end
  end

  // ==========================================================================
  // Control register: bit 0 runs the sequencer, bits 6:4 the start segment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_en_ff    <= 1'b0;
      start_seg_ff <= '0;
    end else if (bus_wr && paddr == RSQ_CTRL_OFS) begin
      run_en_ff    <= pwdata[0];
      start_seg_ff <= pwdata[6:4];
    end
  end

  // APB read path: zero wait state, unmapped access errors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= RSQ_ZERO32;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= RSQ_ZERO32;
      if (psel && !penable) begin
        if (paddr == RSQ_CTRL_OFS) begin
          prdata <= {25'h0, start_seg_ff, 3'h0, run_en_ff};
        end else if (paddr == RSQ_STAT_OFS) begin
          prdata <= {16'h0, tick_cnt_ff[15:8], 1'b0, ramp_out.fast_lock_en, ramp_out.ramp_marker_high,
                     ramp_out.ramp_marker_low, state_ff, seg_ff};
        end else if (paddr == RSQ_ACC_OFS) begin
          prdata <= acc_ff;
        end else if (seg_hit(paddr) && !paddr[2]) begin
          prdata <= {2'h0, shadow_a_ff[seg_of(paddr)][RSQ_INC_W-1:0]};
        end else if (seg_hit(paddr)) begin
          prdata <= unpack_b(shadow_a_ff[seg_of(paddr)]);
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule // rsq_ramp_segment_sequencer
`default_nettype wire

// ---- rsq_pkg.sv ----
`default_nettype none
package rsq_pkg;
  // ==========================================================================
  // Segment table geometry
  localparam int RSQ_NSEG      = 8;
  localparam int RSQ_SEG_W     = 3;
  localparam int RSQ_INC_W     = 30;
  localparam int RSQ_LEN_W     = 16;
  localparam int RSQ_ACC_W     = 32;
  localparam int RSQ_CFG_W     = 56;

  // ==========================================================================
  // Register map: one control, one status and one accumulator word, then two words per segment
  localparam logic [11:0] RSQ_CTRL_OFS = 12'h000;
  localparam logic [11:0] RSQ_STAT_OFS = 12'h004;
  localparam logic [11:0] RSQ_ACC_OFS  = 12'h008;
  localparam logic [11:0] RSQ_SEG_BASE = 12'h040;
  localparam logic [11:0] RSQ_SEG_END  = 12'h080;

  // Word A of a segment: increment in [29:0]
  // Word B of a segment: length-1 [15:0], successor [18:16], source [21:20],
  // flags [25:24], half rate [28], accum clear [29], fast lock [30]
  localparam int RSQ_B_LEN  = 0;
  localparam int RSQ_B_NXT  = 16;
  localparam int RSQ_B_SRC  = 20;
  localparam int RSQ_B_FLG  = 24;
  localparam int RSQ_B_HR   = 28;
  localparam int RSQ_B_CLR  = 29;
  localparam int RSQ_B_FL   = 30;

  localparam logic [RSQ_CFG_W-1:0] RSQ_CFG_RST = '0;
  localparam logic [31:0]          RSQ_ZERO32  = 32'h0000_0000;

  // ==========================================================================
  // Advance sources
  typedef enum logic [1:0] {
    RSQ_ADV_LEN  = 2'b00,
    RSQ_ADV_TRGA = 2'b01,
    RSQ_ADV_TRGB = 2'b10,
    RSQ_ADV_TRGC = 2'b11
  } rsq_adv_t;

  typedef enum logic [0:0] {
    RSQ_ST_IDLE = 1'b0,
    RSQ_ST_RUN  = 1'b1
  } rsq_state_t;

  // One segment's controls, packed
  typedef struct packed {
    logic                 fast_lock;
    logic                 accum_clear;
    logic                 half_rate;
    logic [1:0]           flag_field;
    rsq_adv_t             advance_source;
    logic [RSQ_SEG_W-1:0] successor;
    logic [RSQ_LEN_W-1:0] length;
    logic [RSQ_INC_W-1:0] increment;
  } rsq_seg_t;

  // Outputs toward the divider logic
  typedef struct packed {
    logic                 ramp_marker_high;
    logic                 ramp_marker_low;
    logic                 fast_lock_en;
    logic [RSQ_SEG_W-1:0] segment;
    logic [RSQ_ACC_W-1:0] accum;
  } rsq_out_t;
endpackage
`default_nettype wire

// ---- rsq_seg_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
// Segment table: one write port for a whole entry, registered read of one entry
module rsq_seg_mem #(
  parameter int DEPTH = 8,
  parameter int AW    = 3,
  parameter int W     = 56
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_idx,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic [AW-1:0] rd_idx,
  output var  logic [W-1:0]  rd_data
);
  logic [W-1:0] mem_ff [DEPTH];

  // ==========================================================================
  // Storage, cleared at reset so each field starts at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (wr_en) begin
      mem_ff[wr_idx] <= wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_ff[rd_idx];
    end
  end
endmodule // rsq_seg_mem
`default_nettype wire

// ---- rsq_seq_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bus handshake, refusal and reset checks
module rsq_seq_sva (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire rsq_pkg::rsq_out_t ramp_out
);
  import rsq_pkg::*;
  // Zero-wait slave: any stall here means the decode path grew a stage
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc; psel && !penable ##1 psel && penable; endsequence
  property p_rdy_acc; s_acc |-> pready; endproperty
  a_rdy_acc: assert property (p_rdy_acc) else $error("pready missing in access");
  property p_rdy_one; pready |=> !pready; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready held over");
  property p_rdy_idle; !penable |-> !pready; endproperty
  a_rdy_idle: assert property (p_rdy_idle) else $error("pready outside access");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  // Holes in the map refuse with zero data
  property p_err_hole; psel && penable && paddr inside {[12'h00C:12'h03F]} |-> pslverr && prdata == 32'h0; endproperty
  a_err_hole: assert property (p_err_hole) else $error("hole not refused");
  property p_err_top; psel && penable && paddr >= 12'h080 |-> pslverr && prdata == 32'h0; endproperty
  a_err_top: assert property (p_err_top) else $error("top not refused");
  property p_ok_seg; psel && penable && paddr inside {[12'h040:12'h07F]} |-> !pslverr; endproperty
  a_ok_seg: assert property (p_ok_seg) else $error("segment table refused");
  property p_rst_zero; $rose(presetn) |-> ramp_out == '0 && !pready; endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("outputs not clear after reset");
endmodule // rsq_seq_sva
bind rsq_ramp_segment_sequencer rsq_seq_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ramp_out(ramp_out));
`default_nettype wire

// ---- rsq_trig_src.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Trigger source model
module rsq_trig_src (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       fire,
  input  wire logic [1:0] sel,
  input  wire logic [3:0] dly,
  output var  logic       trigger_a,
  output var  logic       trigger_b,
  output var  logic       trigger_c
);
  logic [3:0] cnt_ff;
  logic [1:0] sel_ff;
  logic       arm_ff;
  // Delay, then one cycle high: the shortest level the sequencer must catch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_ff <= 1'h0;
      cnt_ff <= 4'h0;
      sel_ff <= 2'h0;
      {trigger_c, trigger_b, trigger_a} <= 3'h0;
    end else begin
      {trigger_c, trigger_b, trigger_a} <= 3'h0;
      if (fire) begin
        arm_ff <= 1'h1;
        cnt_ff <= dly;
        sel_ff <= sel;
      end else if (arm_ff && cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
      end else if (arm_ff) begin
        arm_ff <= 1'h0;
        {trigger_c, trigger_b, trigger_a} <= 3'h1 << (sel_ff - 2'h1);
      end
    end
  end
endmodule // rsq_trig_src
`default_nettype wire

// ---- rsq_ramp_segment_sequencer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsq_ramp_segment_sequencer_tb_top;
  import rsq_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, fire;
  logic        trigger_a, trigger_b, trigger_c;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  sel;
  logic [3:0]  dly;
  rsq_out_t    ramp_out;
  int          err_count, check_count, n;
  // ==========================================
  // Design, trigger model and clock
  rsq_ramp_segment_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_a(trigger_a), .trigger_b(trigger_b), .trigger_c(trigger_c), .ramp_out(ramp_out));
  rsq_trig_src trig_u (.pclk(pclk), .presetn(presetn), .fire(fire), .sel(sel), .dly(dly),
    .trigger_a(trigger_a), .trigger_b(trigger_b), .trigger_c(trigger_c));
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  // Hang guard counts as a mismatch
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    final_report;
  end
  // ==========================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    if (k >= 50) begin
      err_count++;
      final_report;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Word A first: word B commits the segment
  task automatic seg(input logic [2:0] i, input logic [31:0] a, input logic [31:0] b);
    apb(1'h1, RSQ_SEG_BASE + {6'h00, i, 3'h0}, a);
    apb(1'h1, RSQ_SEG_BASE + {6'h00, i, 3'h4}, b);
  endtask
  function automatic logic [31:0] wb(input logic [15:0] len, input logic [2:0] nx, input rsq_adv_t src,
                                     input logic [1:0] flg, input logic [2:0] opt);
    return {1'h0, opt, 2'h0, flg, 2'h0, src, 1'h0, nx, len - 16'h1};
  endfunction
  function automatic logic [31:0] fls();
    return {29'h0, ramp_out.fast_lock_en, ramp_out.ramp_marker_high, ramp_out.ramp_marker_low};
  endfunction
  task automatic trig(input logic [1:0] s, input logic [3:0] d);
    @(posedge pclk);
    sel <= s;
    dly <= d;
    fire <= 1'h1;
    @(posedge pclk);
    fire <= 1'h0;
  endtask
  task automatic wait_seg(input logic [2:0] s);
    n = 0;
    while (ramp_out.segment !== s && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200) begin
      err_count++;
      final_report;
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, fire} = '0;
    paddr = '0;
    pwdata = '0;
    sel = '0;
    dly = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, RSQ_STAT_OFS, RSQ_ZERO32);
    chk(rd, RSQ_ZERO32);
    for (int i = 0; i < 8; i++) begin
      apb(1'h0, RSQ_SEG_BASE + {6'h00, 3'(i), 3'h0}, RSQ_ZERO32);
      chk(rd, RSQ_ZERO32);
      seg(3'(i), 32'h0AAA_AA00 + 32'(i), RSQ_ZERO32);
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'h0, RSQ_SEG_BASE + {6'h00, 3'(i), 3'h0}, RSQ_ZERO32);
      chk(rd, 32'h0AAA_AA00 + 32'(i));
    end
    apb(1'h0, 12'h020, RSQ_ZERO32);
    chk({31'h0, er}, 32'h1);
    apb(1'h0, RSQ_SEG_END, RSQ_ZERO32);
    chk({31'h0, er}, 32'h1);
    $display("test table done");
    // Profile: 0 by length, 2 on B, 1 on A with clear, 3 half rate, 5 on C
    seg(3'h0, 32'h3FFF_FFFB, wb(16'h4, 3'h2, RSQ_ADV_LEN, 2'h1, 3'h4));
    seg(3'h2, RSQ_ZERO32, wb(16'h1, 3'h1, RSQ_ADV_TRGB, 2'h3, 3'h0));
    seg(3'h1, RSQ_ZERO32, wb(16'h1, 3'h3, RSQ_ADV_TRGA, 2'h2, 3'h2));
    seg(3'h3, 32'h1, wb(16'h8, 3'h5, RSQ_ADV_LEN, 2'h0, 3'h1));
    seg(3'h5, RSQ_ZERO32, wb(16'h1, 3'h0, RSQ_ADV_TRGC, 2'h1, 3'h0));
    apb(1'h0, RSQ_SEG_BASE + 12'h01C, RSQ_ZERO32);
    chk(rd, wb(16'h8, 3'h5, RSQ_ADV_LEN, 2'h0, 3'h1));
    apb(1'h1, RSQ_CTRL_OFS, 32'h1);
    // Fast lock shows one edge after the markers, as the load cycle holds it off
    repeat (4) @(posedge pclk);
    chk(fls(), 32'h5);
    wait_seg(3'h2);
    repeat (3) @(posedge pclk);
    chk(ramp_out.accum, 32'hFFFF_FFEC);
    chk(fls(), 32'h3);
    trig(2'h1, 4'h0);
    repeat (8) @(posedge pclk);
    chk({29'h0, ramp_out.segment}, 32'h2);
    trig(2'h2, 4'h9);
    wait_seg(3'h1);
    repeat (3) @(posedge pclk);
    chk(ramp_out.accum, RSQ_ZERO32);
    chk(fls(), 32'h2);
    trig(2'h1, 4'h3);
    wait_seg(3'h3);
    wait_seg(3'h5);
    chk({31'h0, (n >= 16 && n <= 18)}, 32'h1);
    repeat (3) @(posedge pclk);
    chk(ramp_out.accum, 32'h8);
    chk(fls(), 32'h1);
    trig(2'h3, 4'h0);
    wait_seg(3'h0);
    chk({29'h0, ramp_out.segment}, RSQ_ZERO32);
    $display("test profile done");
    // Reset in mid-run: the whole table and the sequencer return to zero
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, RSQ_STAT_OFS, RSQ_ZERO32);
    chk(rd, RSQ_ZERO32);
    apb(1'h0, RSQ_SEG_BASE, RSQ_ZERO32);
    chk(rd, RSQ_ZERO32);
    chk(ramp_out.accum, RSQ_ZERO32);
    $display("test reset done");
    final_report;
  end
endmodule // rsq_ramp_segment_sequencer_tb_top
`default_nettype wire
